// ### rtl/dflp_pkg.sv
// ============================================================
// constants shared by the line port
package dflp_pkg;
   // nominal extracted clock rates and master clock rate
   localparam int unsigned EXCLK_E1_HZ = 2048000;
   localparam int unsigned EXCLK_T1_HZ = 1544000;
   localparam int unsigned MCLK_HZ     = 125000000;

   // frame and multiframe lengths
   localparam logic [8:0] FRAME_BITS_E1 = 9'h100;   // 256 bits
   localparam logic [8:0] FRAME_BITS_T1 = 9'h0c1;   // 193 bits
   localparam logic [4:0] MF_FRAMES_E1  = 5'h10;    // 16 frames
   localparam logic [4:0] MF_FRAMES_T1  = 5'h18;    // 24 frames

   // first data-link bit inside the odd frame of a frame pair
   localparam logic [9:0] DL_FIRST_BIT  = 10'h003;

   // synchroniser lane count and input lanes
   localparam int unsigned SYNC_LANES = 4;
   localparam int unsigned LANE_EXCLK = 0;
   localparam int unsigned LANE_TIP   = 1;
   localparam int unsigned LANE_RING  = 2;
   localparam int unsigned LANE_MARK  = 3;

   // data-link rate select: data-link bits per two frames
   typedef enum logic [2:0] {
      DFLP_DL_4K  = 3'h0,
      DFLP_DL_8K  = 3'h1,
      DFLP_DL_12K = 3'h2,
      DFLP_DL_16K = 3'h3,
      DFLP_DL_20K = 3'h4
   } dflp_dl_rate_e;

   // gapped clock phases, gray except the step from HIGH back to IDLE
   typedef enum logic [1:0] {
      DFLP_DLC_IDLE = 2'h0,
      DFLP_DLC_WAIT = 2'h1,
      DFLP_DLC_HIGH = 2'h3
   } dflp_dlc_state_e;
endpackage

// ### rtl/dflp_sync.sv
`timescale 1ns/1ps
// ============================================================
// three-stage pin synchroniser with agreement filter
module dflp_sync (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic s1;
   logic s2;
   logic s3;

   // s1 feeds only s2
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // accept a change once stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         level <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end else begin
         rise <= (s2 == s3) && s2 && !level;
         fall <= (s2 == s3) && !s2 && level;
         if (s2 == s3) begin
            level <= s2;
         end
      end
   end
endmodule

// ### rtl/dflp_line_port.sv
`timescale 1ns/1ps
// Summary of operation
// (R01) transmit outputs work only while the internal line interface is disabled
// (R02) nrz select high: single-rail data on primary pin, secondary idle
// (R03) nrz select low: primary and secondary form a complementary dual-rail pair
// (R04) received data accepted as split-phase tip/ring pair or nrz on tip
// (R05) data-link serial stream of received bits, launched on extracted clock rise
// (R06) gapped data-link clock at 4, 8, 12, 16 or 20 kHz
// (R07) outside receiver samples data-link bits on the gapped clock rise
// (R08) low mark on multiframe input aligns the transmit multiframe
// (R09) multiframe input high: transmit multiframe boundaries generated internally
// (R10) multiframe input is normally tied high by the system
// (R11) extracted clock, 2.048 or 1.544 MHz, captures received data
// (R12) one gapped clock rise per data-link bit, bit stable, low in gaps
module dflp_line_port (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        exclk,
   input  wire logic        rx_tip,
   input  wire logic        rx_ring,
   input  wire logic        transmit_multiframe_mark_n,
   input  wire logic        framer_only,
   input  wire logic        nrz_select,
   input  wire logic        rx_nrz_mode,
   input  wire logic        e1_mode,
   input  wire logic [2:0]  dl_rate,
   input  wire logic        tx_bit,
   input  wire logic        rx_pair_start,
   output logic             tx_bit_taken,
   output logic             tx_frame_start,
   output logic             tx_multiframe_start,
   output logic             transmit_line_primary,
   output logic             transmit_line_secondary,
   output logic             rx_bit,
   output logic             rx_bit_valid,
   output logic             datalink_serial_out,
   output logic             datalink_gapped_clock
);
   // ============================================================
   // pin synchronisers
   logic [dflp_pkg::SYNC_LANES-1:0] pins;
   logic [dflp_pkg::SYNC_LANES-1:0] lvl;
   logic [dflp_pkg::SYNC_LANES-1:0] rise;
   logic [dflp_pkg::SYNC_LANES-1:0] fall;

   assign pins = {transmit_multiframe_mark_n, rx_ring, rx_tip, exclk};

   // one synchroniser per asynchronous pin
   genvar g;
   generate
      for (g = 0; g < dflp_pkg::SYNC_LANES; g++) begin : g_sync
         dflp_sync u_sync (
            .mclk  (mclk),
            .rst   (rst),
            .pin   (pins[g]),
            .level (lvl[g]),
            .rise  (rise[g]),
            .fall  (fall[g])
         );
      end
   endgenerate

   logic ex_rise;
   logic ex_fall;
   assign ex_rise = rise[dflp_pkg::LANE_EXCLK];
   assign ex_fall = fall[dflp_pkg::LANE_EXCLK];

   // ============================================================
   // transmit framing
   logic [8:0] frame_len;
   logic [4:0] mf_len;
   logic [8:0] tx_pos;
   logic [4:0] tx_frame;
   logic       mark_seen;

   assign frame_len = e1_mode ? dflp_pkg::FRAME_BITS_E1 : dflp_pkg::FRAME_BITS_T1;
   assign mf_len    = e1_mode ? dflp_pkg::MF_FRAMES_E1 : dflp_pkg::MF_FRAMES_T1;

   // latch a falling mark until the next bit boundary
   always_ff @(posedge mclk) begin
      if (rst) begin
         mark_seen <= 1'b0;
      end else if (fall[dflp_pkg::LANE_MARK]) begin
         mark_seen <= 1'b1;                                      // R08
      end else if (ex_rise) begin
         mark_seen <= 1'b0;
      end
   end

   // bit and frame counters; a mark restarts the multiframe
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_pos   <= 9'h000;
         tx_frame <= 5'h00;
      end else if (ex_rise) begin
         if (mark_seen) begin
            tx_pos   <= 9'h001;                                  // R08
            tx_frame <= 5'h00;
         end else if (tx_pos == frame_len - 9'h001) begin
            tx_pos   <= 9'h000;                                  // R09
            tx_frame <= (tx_frame >= mf_len - 5'h01) ? 5'h00 : tx_frame + 5'h01;
         end else begin
            tx_pos <= tx_pos + 9'h001;
         end
      end
   end

   // boundary strobes for the framer, one cycle each
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_bit_taken        <= 1'b0;
         tx_frame_start      <= 1'b0;
         tx_multiframe_start <= 1'b0;
      end else begin
         tx_bit_taken        <= ex_rise && framer_only;
         tx_frame_start      <= ex_rise && framer_only && (mark_seen || tx_pos == 9'h000);
         tx_multiframe_start <= ex_rise && framer_only
                                && (mark_seen || (tx_pos == 9'h000 && tx_frame == 5'h00));
      end
   end

   // ============================================================
   // transmit line drive
   // launch on extracted clock rise; quiet unless framer only
   always_ff @(posedge mclk) begin
      if (rst) begin
         transmit_line_primary   <= 1'b0;
         transmit_line_secondary <= 1'b0;
      end else if (!framer_only) begin
         transmit_line_primary   <= 1'b0;                        // R01
         transmit_line_secondary <= 1'b0;
      end else begin
         if (ex_rise) begin
            transmit_line_primary <= tx_bit;                     // R02 R03
         end
         // secondary has no function in nrz, so drop it at once, not at the next launch
         if (nrz_select) begin
            transmit_line_secondary <= 1'b0;                     // R02
         end else if (ex_rise) begin
            transmit_line_secondary <= ~tx_bit;                  // R03
         end
      end
   end

   // ============================================================
   // receive capture
   logic rx_now;
   // split-phase marks on either rail, or nrz on tip alone
   assign rx_now = rx_nrz_mode ? lvl[dflp_pkg::LANE_TIP]
                               : (lvl[dflp_pkg::LANE_TIP] | lvl[dflp_pkg::LANE_RING]);   // R04

   // capture each received bit on the extracted clock rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_bit       <= 1'b0;
         rx_bit_valid <= 1'b0;
      end else begin
         rx_bit_valid <= ex_rise;                                // R11
         if (ex_rise) begin
            rx_bit <= rx_now;                                    // R04 R11
         end
      end
   end

   // ============================================================
   // data-link extraction
   logic [9:0] rx_pos;
   logic [9:0] dl_lo;
   logic [9:0] dl_hi;
   logic [2:0] dl_count;
   logic       dl_take;

   // bits per frame pair: rate select plus one, capped at five
   assign dl_count = (dl_rate > 3'(dflp_pkg::DFLP_DL_20K)) ? 3'h5 : dl_rate + 3'h1;
   assign dl_lo    = {1'b0, frame_len} + dflp_pkg::DL_FIRST_BIT;
   assign dl_hi    = dl_lo + {7'h00, dl_count};
   assign dl_take  = ex_rise && (rx_pos >= dl_lo) && (rx_pos < dl_hi);   // R06

   // position inside the received frame pair
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_pos <= 10'h000;
      end else if (rx_pair_start) begin
         rx_pos <= 10'h000;
      end else if (ex_rise) begin
         rx_pos <= (rx_pos == {frame_len, 1'b0} - 10'h001) ? 10'h000 : rx_pos + 10'h001;
      end
   end

   // ============================================================
   // gapped data-link clock
   dflp_pkg::dflp_dlc_state_e dlc_state;

   // launch bit on rise, raise clock on next fall, drop on next rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         dlc_state             <= dflp_pkg::DFLP_DLC_IDLE;
         datalink_serial_out   <= 1'b0;
         datalink_gapped_clock <= 1'b0;
      end else begin
         if (dl_take) begin
            datalink_serial_out <= rx_now;                       // R05
         end
         unique case (dlc_state)
            dflp_pkg::DFLP_DLC_IDLE: begin
               datalink_gapped_clock <= 1'b0;                    // R12
               if (dl_take) begin
                  dlc_state <= dflp_pkg::DFLP_DLC_WAIT;
               end
            end
            dflp_pkg::DFLP_DLC_WAIT: begin
               if (ex_fall) begin
                  datalink_gapped_clock <= 1'b1;                 // R07 R12
                  dlc_state             <= dflp_pkg::DFLP_DLC_HIGH;
               end
            end
            dflp_pkg::DFLP_DLC_HIGH: begin
               if (ex_rise) begin
                  datalink_gapped_clock <= 1'b0;                 // R12
                  dlc_state <= dl_take ? dflp_pkg::DFLP_DLC_WAIT : dflp_pkg::DFLP_DLC_IDLE;
               end
            end
            default: begin
               datalink_gapped_clock <= 1'b0;
               dlc_state             <= dflp_pkg::DFLP_DLC_IDLE;
            end
         endcase
      end
   end
endmodule

// ### dv/dflp_line_port_properties.sv
`timescale 1ns/1ps
// ============================================================
// pin-level checks of the line port
module dflp_line_port_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic framer_only,
   input wire logic nrz_select,
   input wire logic tx_bit_taken,
   input wire logic tx_frame_start,
   input wire logic tx_multiframe_start,
   input wire logic transmit_line_primary,
   input wire logic transmit_line_secondary,
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic datalink_serial_out,
   input wire logic datalink_gapped_clock
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ============================================================
   // transmit side
   a_tx_off_idle: assert property (!framer_only && !$past(framer_only) |->
      !(tx_bit_taken | transmit_line_primary | transmit_line_secondary)) else $error("tx active while off");
   a_nrz_sec_idle: assert property (nrz_select && $past(nrz_select) |-> !transmit_line_secondary)
      else $error("secondary driven in nrz");
   a_dual_rail: assert property (tx_bit_taken && !nrz_select && !$past(nrz_select) |->
      transmit_line_secondary != transmit_line_primary) else $error("rails not complementary");
   a_tx_hold: assert property (framer_only && $past(framer_only) && !tx_bit_taken |->
      $stable(transmit_line_primary)) else $error("primary moved without launch");
   a_mf_in_frame: assert property (tx_multiframe_start |-> tx_frame_start && tx_bit_taken)
      else $error("multiframe start off frame");
   // ============================================================
   // data-link side
   a_dl_launch: assert property ($changed(datalink_serial_out) |-> rx_bit_valid && datalink_serial_out == rx_bit)
      else $error("data-link bit not from capture");
   a_dlclk_high: assert property ($rose(datalink_gapped_clock) |-> datalink_gapped_clock[*4])
      else $error("gapped clock pulse short");
   a_dlclk_gap: assert property (datalink_gapped_clock |-> !rx_bit_valid)
      else $error("gapped clock high over launch");
   c_mf: cover property (tx_multiframe_start);
   c_dlclk: cover property ($rose(datalink_gapped_clock));
   c_dual: cover property (tx_bit_taken && !nrz_select);
endmodule

bind dflp_line_port dflp_line_port_props u_props (.mclk, .rst, .framer_only, .nrz_select,
   .tx_bit_taken, .tx_frame_start, .tx_multiframe_start, .transmit_line_primary,
   .transmit_line_secondary, .rx_bit, .rx_bit_valid, .datalink_serial_out, .datalink_gapped_clock);

// ### dv/dflp_phy_model.sv
`timescale 1ns/1ps
// ============================================================
// far-side line device: clock, receive rails, data-link sink
module dflp_phy_model (
   input  wire logic        nrz,
   input  wire logic        dl_clk,
   input  wire logic        dl_data,
   output logic             exclk,
   output logic             tip,
   output logic             ring,
   output logic             bit_now,
   output logic [15:0]      dl_rises,
   output logic [15:0]      dl_bits
);
   logic [15:0] pat = 16'h9d2b;
   logic        alt = 1'b0;
   initial exclk = 1'b0;
   initial bit_now = 1'b0;
   initial dl_rises = 16'h0000;
   initial dl_bits = 16'h0000;
   initial {tip, ring} = 2'b00;
   // free-running extracted clock, far slower than mclk
   always #100 exclk = ~exclk;
   // next bit on each fall; split-phase ones alternate rails, unused ring inverted
   always @(negedge exclk) begin
      pat <= {pat[14:0], pat[15]};
      bit_now <= pat[15];
      alt <= alt ^ pat[15];
      tip <= nrz ? pat[15] : pat[15] & !alt;
      ring <= nrz ? ~pat[15] : pat[15] & alt;
   end
   // data-link bits taken on the gapped clock rise
   always @(posedge dl_clk) begin
      dl_rises <= dl_rises + 16'h0001;
      dl_bits <= {dl_bits[14:0], dl_data};
   end
endmodule

// ### dv/dflp_tb.sv
`timescale 1ns/1ps
// ============================================================
// line port testbench
module tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        transmit_multiframe_mark_n = 1'b1; // high except while t_mark drives it low, internal multiframe
   logic        framer_only = 1'b0, nrz_select = 1'b1, rx_nrz_mode = 1'b1, e1_mode = 1'b0;
   logic        tx_bit = 1'b0, rx_pair_start = 1'b0;
   logic [2:0]  dl_rate = 3'h0;
   logic        tx_bit_taken, tx_frame_start, tx_multiframe_start, transmit_line_primary;
   logic        transmit_line_secondary, rx_bit, rx_bit_valid, datalink_serial_out;
   logic        datalink_gapped_clock, exclk, rx_tip, rx_ring, bit_now;
   logic [15:0] dl_rises, dl_bits;
   int          fail_count = 0;
   int          num_checks = 0;
   always #4 mclk = ~mclk;
   dflp_line_port DUT (.mclk, .rst, .exclk, .rx_tip, .rx_ring, .transmit_multiframe_mark_n,
      .framer_only, .nrz_select, .rx_nrz_mode, .e1_mode, .dl_rate, .tx_bit, .rx_pair_start,
      .tx_bit_taken, .tx_frame_start, .tx_multiframe_start, .transmit_line_primary,
      .transmit_line_secondary, .rx_bit, .rx_bit_valid, .datalink_serial_out, .datalink_gapped_clock);
   dflp_phy_model u_phy (.nrz(rx_nrz_mode), .dl_clk(datalink_gapped_clock), .dl_data(datalink_serial_out),
      .exclk, .tip(rx_tip), .ring(rx_ring), .bit_now, .dl_rises, .dl_bits);
   // ============================================================
   // compares, bounded waits and verdict
   task automatic chk_bit(string nm, logic e, logic g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_cnt(string nm, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // sel 0 launch, 1 capture, 2 multiframe start
   task automatic wait_ev(input int sel);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while ((sel == 0 ? tx_bit_taken : sel == 1 ? rx_bit_valid : tx_multiframe_start) !== 1'b1 && n < 80);
      if (n == 80) begin
         chk_bit("strobe wait", 1'b1, 1'b0);
         conclude();
      end
   endtask
   // ============================================================
   // scenarios
   task automatic t_off();
      framer_only = 1'b0;
      tx_bit = 1'b1;
      repeat (4) @(posedge mclk);
      repeat (60) begin
         @(posedge mclk);
         #1;
         chk_bit("tx off", 1'b0, tx_bit_taken | transmit_line_primary | transmit_line_secondary);
      end
      $display("t_off done");
   endtask
   task automatic t_tx(input logic nrz);
      logic [7:0] p;
      p = 8'hb4;
      framer_only = 1'b1;
      nrz_select = nrz;
      wait_ev(0);
      for (int i = 0; i < 8; i++) begin
         tx_bit = p[i];
         wait_ev(0);
         chk_bit("primary", p[i], transmit_line_primary);
         chk_bit("secondary", nrz ? 1'b0 : ~p[i], transmit_line_secondary);
      end
      $display("t_tx done");
   endtask
   task automatic t_rx(input logic nrz);
      rx_nrz_mode = nrz;
      wait_ev(1);
      repeat (16) begin
         wait_ev(1);
         chk_bit("rx bit", bit_now, rx_bit);
      end
      $display("t_rx done");
   endtask
   task automatic t_dl(input logic [2:0] rate);
      logic [15:0] r0;
      logic [15:0] e;
      int          lo;
      int          k;
      // data-link slots start three bits into the odd frame; rates above the top one act as the top one
      lo = int'(dflp_pkg::FRAME_BITS_T1) + int'(dflp_pkg::DL_FIRST_BIT);
      k = (rate > 3'(dflp_pkg::DFLP_DL_20K)) ? 5 : int'(rate) + 1;
      dl_rate = rate;
      wait_ev(1);
      rx_pair_start = 1'b1;
      @(posedge mclk);
      #1;
      rx_pair_start = 1'b0;
      repeat (2) wait_ev(1);
      r0 = dl_rises;
      e = dl_bits;
      for (int i = 2; i < 388; i++) begin
         wait_ev(1);
         if (i >= lo && i < lo + k) e = {e[14:0], bit_now};
      end
      chk_cnt("dl rises", k[15:0], dl_rises - r0);
      chk_cnt("dl bits", e, dl_bits);
      $display("t_dl done");
   endtask
   task automatic t_mark();
      int n;
      e1_mode = 1'b1;
      transmit_multiframe_mark_n = 1'b0;
      wait_ev(2);
      chk_bit("frame at mark", 1'b1, tx_frame_start);
      transmit_multiframe_mark_n = 1'b1;
      n = 0;
      do begin
         wait_ev(0);
         n++;
      end while (tx_frame_start !== 1'b1 && n < 300);
      chk_cnt("frame bits", {7'h00, dflp_pkg::FRAME_BITS_E1}, n[15:0]);
      chk_bit("mf start", 1'b0, tx_multiframe_start);
      $display("t_mark done");
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_off();
      t_tx(1'b1);
      t_tx(1'b0);
      t_rx(1'b1);
      t_rx(1'b0);
      for (int r = 0; r < 6; r++) t_dl(r == 5 ? 3'h7 : r[2:0]);
      t_mark();
      conclude();
   end
endmodule
